/* as_ant_model.sv */
`timescale 1ns/1ps
`default_nettype none
module as_ant_model (
  // fault controls
  input wire shorted,
  input wire present,
  // antenna pins
  input wire supply_off_out,
  output wire short_sense_low,
  output wire presence_sense
);
  // a short only pulls low while current flows, the pull-up wins otherwise
  assign short_sense_low = !(shorted && !supply_off_out);
  // no supply means no current, so presence reads low then
  assign presence_sense = present && !supply_off_out;
endmodule // as_ant_model
`default_nettype wire

/* as_map.vh */
`ifndef AS_MAP_VH
`define AS_MAP_VH
// register indices (byte address = index, plain port)
`define AS_REG_CTRL 4'h0
`define AS_REG_STATUS 4'h1
`define AS_REG_IRQ_STAT 4'h2
`define AS_REG_IRQ_MASK 4'h3
`define AS_REG_REPORT 4'h4
`define AS_REG_RECOVER 4'h5
// control bits
`define AS_CTRL_SUPPLY 0
`define AS_CTRL_SHORT 1
`define AS_CTRL_PWRDN 2
`define AS_CTRL_RECOVER 3
`define AS_CTRL_OPEN 4
`define AS_CTRL_RESET 5'h00
// antenna conditions
`define AS_COND_INIT 2'h0
`define AS_COND_OK 2'h1
`define AS_COND_SHORT 2'h2
`define AS_COND_OPEN 2'h3
// report kinds
`define AS_KIND_FEATURE 1'b1
`define AS_KIND_COND 1'b0
// interrupt bits
`define AS_IRQ_REPORT 0
`define AS_IRQ_SHORT 1
`define AS_IRQ_OPEN 2
// recovery timeout: 1000 us at 20 MHz
`define AS_CLK_MHZ 20
`define AS_RECOVER_US 1000
`define AS_RECOVER_CYCLES (`AS_RECOVER_US * `AS_CLK_MHZ)
`endif

/* as_supervisor.v */
// Behaviour
// (RULE1) no reports while supply control disabled
// (RULE2) ctrl bit 0 enables supply control
// (RULE3) supply_off_out high switches antenna off
// (RULE4) ctrl bit 1 enables short detection
// (RULE5) short sense is active low, pulled up
// (RULE6) short without power-down keeps power on
// (RULE7) power-down on short off after reset
// (RULE8) short status latched until recovery/re-enable
// (RULE9) ctrl bit 3 enables short recovery
// (RULE10) recovery+power-down: supply off, status short
// (RULE11) after timeout retest; clear gives ok
// (RULE12) ctrl bit 4 enables open detection
// (RULE13) low presence with open detect reports open
// (RULE14) high presence reports antenna ok
// (RULE15) report on every status change
// (RULE16) start-up: features, init, then status
// (RULE17) initial status ok when antenna present
// (RULE18) two-flop synchronise both sense inputs
// (RULE19) recovery timeout counts clocks, restarts on off
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "as_map.vh"
module as_supervisor #(
  parameter [31:0] RECOVER_CYCLES = `AS_RECOVER_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // antenna pins
  input wire short_sense_low,
  input wire presence_sense,
  output reg supply_off_out,
  // status and interrupt
  output reg power_on,
  output reg [1:0] condition,
  output reg irq
);

////////////////////////////////////////////////////////////////////////////
// synchronisers
reg [1:0] short_sync;
reg [1:0] pres_sync;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    short_sync <= 2'h3;
    pres_sync <= 2'h3;
  end else begin
    short_sync <= {short_sync[0], short_sense_low}; // RULE18
    pres_sync <= {pres_sync[0], presence_sense}; // RULE18
  end
end
// pin idles high (pull-up outside) so high means no short
wire shorted = ~short_sync[1]; // RULE5
wire absent = ~pres_sync[1]; // RULE13

////////////////////////////////////////////////////////////////////////////
// control register
reg [4:0] ctrl;
wire en_supply = ctrl[`AS_CTRL_SUPPLY];
wire en_short = ctrl[`AS_CTRL_SHORT];
wire en_pwrdn = ctrl[`AS_CTRL_PWRDN];
wire en_recover = ctrl[`AS_CTRL_RECOVER];
wire en_open = ctrl[`AS_CTRL_OPEN];
wire wr_ctrl = reg_wr && reg_addr == `AS_REG_CTRL;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    ctrl <= `AS_CTRL_RESET; // RULE7
  end else if (wr_ctrl) begin
    ctrl <= reg_wdata[4:0]; // RULE2 RULE4 RULE9 RULE12
  end
end

////////////////////////////////////////////////////////////////////////////
// supervisor state
reg short_latched;
reg supply_cut;
reg [31:0] recover_cnt;
reg prev_short_en;
reg started;
wire short_rise_en = en_short && !prev_short_en;
wire timeout = supply_cut && recover_cnt == 32'h0;
// power-down and recovery go together; recovery alone cannot cut supply
wire cut_mode = en_pwrdn && en_recover;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    short_latched <= 1'b0;
    supply_cut <= 1'b0;
    recover_cnt <= 32'h0;
    prev_short_en <= 1'b0;
  end else begin
    prev_short_en <= en_short;
    if (!en_supply || !en_short || short_rise_en) begin
      short_latched <= 1'b0; // RULE8
      supply_cut <= 1'b0;
    end else if (supply_cut) begin
      if (recover_cnt != 32'h0) begin
        recover_cnt <= recover_cnt - 32'h1; // RULE19
      end else begin
        supply_cut <= 1'b0; // RULE11
        short_latched <= 1'b0; // RULE11
      end
    end else if (shorted && !short_latched) begin
      short_latched <= 1'b1; // RULE6 RULE10
      if (cut_mode) begin
        supply_cut <= 1'b1; // RULE10
        recover_cnt <= RECOVER_CYCLES - 32'h1; // RULE19
      end
    end
  end
end

// evaluated condition
reg [1:0] next_cond;
always @* begin
  if (short_latched) begin
    next_cond = `AS_COND_SHORT; // RULE8
  end else if (en_open && absent) begin
    next_cond = `AS_COND_OPEN; // RULE13
  end else begin
    next_cond = `AS_COND_OK; // RULE14 RULE17
  end
end

////////////////////////////////////////////////////////////////////////////
// outputs and report generator
reg [7:0] report;
reg report_valid;
reg [1:0] phase;
localparam PH_FEAT = 2'h0;
localparam PH_INIT = 2'h1;
localparam PH_RUN = 2'h2;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    supply_off_out <= 1'b0;
    power_on <= 1'b1;
    condition <= `AS_COND_INIT;
    report <= 8'h00;
    report_valid <= 1'b0;
    phase <= PH_FEAT;
    started <= 1'b0;
  end else begin
    report_valid <= 1'b0;
    supply_off_out <= supply_cut; // RULE3 RULE6
    power_on <= ~supply_cut; // RULE10
    if (!en_supply) begin
      phase <= PH_FEAT; // RULE1
      condition <= `AS_COND_INIT;
      started <= 1'b0;
    end else begin
      case (phase)
        PH_FEAT: begin
          report <= {`AS_KIND_FEATURE, 2'h0, en_open, en_recover, en_pwrdn, en_short,
            en_supply}; // RULE16
          report_valid <= 1'b1;
          phase <= PH_INIT;
        end
        PH_INIT: begin
          report <= {`AS_KIND_COND, 5'h00, `AS_COND_INIT}; // RULE16
          report_valid <= 1'b1;
          condition <= `AS_COND_INIT;
          phase <= PH_RUN;
        end
        PH_RUN: begin
          if (!started || next_cond != condition) begin
            condition <= next_cond; // RULE15
            report <= {`AS_KIND_COND, 5'h00, next_cond}; // RULE15
            report_valid <= 1'b1;
            started <= 1'b1;
          end
        end
        default: phase <= PH_FEAT;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// interrupts: sticky, write one to clear, set wins
reg [2:0] irq_stat;
reg [2:0] irq_mask;
wire [2:0] irq_set = {report_valid && !report[7] && report[1:0] == `AS_COND_OPEN,
  report_valid && !report[7] && report[1:0] == `AS_COND_SHORT, report_valid};
wire wr_stat = reg_wr && reg_addr == `AS_REG_IRQ_STAT;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    irq_stat <= 3'h0;
    irq_mask <= 3'h0;
    irq <= 1'b0;
  end else begin
    irq_stat <= (irq_stat & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | irq_set;
    if (reg_wr && reg_addr == `AS_REG_IRQ_MASK) begin
      irq_mask <= reg_wdata[2:0];
    end
    irq <= |(((irq_stat & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | irq_set) & irq_mask);
  end
end

////////////////////////////////////////////////////////////////////////////
// read port, data one cycle after strobe; unmapped reads zero
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    reg_rdata <= 8'h00;
  end else if (reg_rd) begin
    case (reg_addr)
      `AS_REG_CTRL: reg_rdata <= {3'h0, ctrl};
      `AS_REG_STATUS: reg_rdata <= {3'h0, shorted, supply_cut, ~supply_cut, condition};
      `AS_REG_IRQ_STAT: reg_rdata <= {5'h00, irq_stat};
      `AS_REG_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
      `AS_REG_REPORT: reg_rdata <= report;
      `AS_REG_RECOVER: reg_rdata <= {7'h00, supply_cut};
      default: reg_rdata <= 8'h00;
    endcase
  end else begin
    reg_rdata <= 8'h00;
  end
end

endmodule // as_supervisor
`default_nettype wire

/* as_supervisor_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module as_sup_chk #(
  parameter [31:0] RECOVER_CYCLES = 32'd8
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  // antenna and status
  input wire short_sense_low,
  input wire presence_sense,
  input wire supply_off_out,
  input wire power_on,
  input wire [1:0] condition
);
  reg [4:0] ctrl;
  reg [31:0] off_cnt;
  // no control write taken now, so ctrl still holds at the next edge
  wire quiet = !(reg_wr && reg_addr == 4'h0);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 5'h00;
      off_cnt <= 32'h0;
    end else begin
      if (!quiet) ctrl <= reg_wdata[4:0];
      off_cnt <= supply_off_out ? off_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  off_unpowered_a: assert property (supply_off_out |-> !power_on)
    else $error("supply cut while power on");
  quiet_idle_a: assert property (!ctrl[0] && quiet && condition == 2'h0 |=> condition == 2'h0)
    else $error("status left init while supervisor off");
  no_cut_a: assert property ((!ctrl[2] || !ctrl[3]) && quiet && !supply_off_out |=> !supply_off_out)
    else $error("supply cut without power-down");
  short_hold_a: assert property (ctrl[1:0] == 2'h3 && !ctrl[3] && quiet && condition == 2'h2
    |=> condition == 2'h2)
    else $error("short status not held");
  short_cut_a: assert property (ctrl[3:0] == 4'hf && $fell(short_sense_low)
    |-> ##[3:8] supply_off_out && condition == 2'h2)
    else $error("short not cut off");
  retest_wait_a: assert property ($fell(supply_off_out) && ctrl[3] |-> off_cnt >= RECOVER_CYCLES - 1)
    else $error("retest before timeout");
  retest_bound_a: assert property (off_cnt <= RECOVER_CYCLES + 4)
    else $error("no retest after timeout");
  open_report_a: assert property (ctrl[0] && ctrl[4] && short_sense_low && $fell(presence_sense)
    |-> ##[3:8] condition == 2'h3)
    else $error("open not reported");
endmodule // as_sup_chk
bind as_supervisor as_sup_chk #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_chk (.*);
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  reg clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, shorted = 1'b0, present = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire short_sense_low, presence_sense, supply_off_out, power_on, irq;
  wire [1:0] condition;
  integer n_errors = 0, checked = 0, i;
  reg [7:0] seen [0:2];
  always #25 clk = ~clk;
  as_supervisor #(.RECOVER_CYCLES(32'd8)) u_dut (.*);
  as_ant_model u_ant (.*);
  ////////////////////////////////////////////////////////////////
  task test_done;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] what, input [23:0] exp, input [23:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk("rdata", {16'h0, exp}, {16'h0, reg_rdata});
      @(posedge clk);
    end
  endtask
  // condition, power, cut, irq in one compare
  task st(input [1:0] c, input p, input o, input q);
    begin
      @(negedge clk);
      chk("state", {19'h0, c, p, o, q}, {19'h0, condition, power_on, supply_off_out, irq});
      @(posedge clk);
    end
  endtask
  task wait_off(input v);
    begin
      for (i = 0; i < 40 && supply_off_out !== v; i = i + 1) @(posedge clk);
      chk("cut", {23'h0, v}, {23'h0, supply_off_out});
      if (supply_off_out !== v) test_done;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h04);
    st(2'h0, 1'b1, 1'b0, 1'b0);
    wr(4'h3, 8'h07);
    $display("test reset done");
    // write control and read the report register every cycle
    reg_addr <= 4'h0;
    reg_wdata <= 8'h01;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= 4'h4;
    for (i = 0; i < 8; i = i + 1) begin
      @(negedge clk);
      if (reg_rdata !== seen[2]) begin
        seen[0] = seen[1];
        seen[1] = seen[2];
        seen[2] = reg_rdata;
      end
    end
    @(posedge clk);
    reg_rd <= 1'b0;
    chk("startup", 24'h810001, {seen[0], seen[1], seen[2]});
    st(2'h1, 1'b1, 1'b0, 1'b1);
    wr(4'h2, 8'hff);
    $display("test startup done");
    wr(4'h0, 8'h03);
    shorted <= 1'b1;
    repeat (10) @(posedge clk);
    st(2'h2, 1'b1, 1'b0, 1'b1);
    shorted <= 1'b0;
    repeat (10) @(posedge clk);
    st(2'h2, 1'b1, 1'b0, 1'b1);
    rd(4'h2, 8'h03);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h03);
    repeat (10) @(posedge clk);
    st(2'h1, 1'b1, 1'b0, 1'b1);
    $display("test short done");
    wr(4'h0, 8'h0f);
    shorted <= 1'b1;
    wait_off(1'b1);
    st(2'h2, 1'b0, 1'b1, 1'b1);
    rd(4'h5, 8'h01);
    wait_off(1'b0);
    wait_off(1'b1);
    shorted <= 1'b0;
    wait_off(1'b0);
    repeat (8) @(posedge clk);
    st(2'h1, 1'b1, 1'b0, 1'b1);
    $display("test recovery done");
    wr(4'h2, 8'hff);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h1f);
    present <= 1'b0;
    repeat (10) @(posedge clk);
    st(2'h3, 1'b1, 1'b0, 1'b0);
    rd(4'h2, 8'h05);
    wr(4'h3, 8'h04);
    st(2'h3, 1'b1, 1'b0, 1'b1);
    wr(4'h2, 8'h04);
    st(2'h3, 1'b1, 1'b0, 1'b0);
    present <= 1'b1;
    repeat (10) @(posedge clk);
    st(2'h1, 1'b1, 1'b0, 1'b0);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h05);
    rd(4'hf, 8'h00);
    $display("test open done");
    test_done;
  end
endmodule // tb
`default_nettype wire
